// ### src/jtag_prog_port.sv
// tap-side programming data registers, page fifo and ahb-lite control regs
//
// Local design decisions: the address map and the AHB-Lite register port.
`timescale 1ns/100ps
`default_nettype none
`include "jtag_prog_consts.svh"

module page_fifo #(
    parameter int WIDTH = 10,
    parameter int DEPTH = 4
) (
    input wire logic clk, // system clock
    input wire logic rst, // async reset
    input wire logic in_valid, // push request
    output logic in_ready, // room left
    input wire logic [WIDTH-1:0] in_data, // pushed word
    output logic out_valid, // word waiting
    input wire logic out_ready, // sink takes word
    output logic [WIDTH-1:0] out_data // head word
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [AW-1:0] wr_q;
    logic [AW-1:0] rd_q;
    logic [AW:0] cnt_q;
    logic push;
    logic pop;

    assign in_ready = (cnt_q != (AW+1)'(DEPTH));
    assign out_valid = (cnt_q != '0);
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;
    assign out_data = mem_q[rd_q];

    // storage has no reset, only pointers and count do
    always_ff @(posedge clk) begin
        if (push) begin
            mem_q[wr_q] <= in_data;
        end
    end

    // pointers wrap; depth is a power of two
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            wr_q <= '0;
            rd_q <= '0;
            cnt_q <= '0;
        end else begin
            if (push) wr_q <= wr_q + 1'b1;
            if (pop) rd_q <= rd_q + 1'b1;
            cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
        end
    end
endmodule

module jtag_prog_port
    import jtag_prog_pkg::*;
#(
    parameter int TOUT_SHORT_CYC = 16,
    parameter int TOUT_LONG_CYC = 6500,
    parameter int FIFO_DEPTH = 4
) (
    input wire logic CLK_SYS, // 100 MHz system clock
    input wire logic RST, // async power-on reset, high
    input wire logic TCK, // test clock pin
    input wire logic TMS, // test mode select pin
    input wire logic TDI, // test data in pin
    output logic TDO, // test data out
    output logic TDO_OE_N, // low while tdo drives
    input wire logic EXT_RESET_N, // external reset pin
    input wire logic PORT_ENABLE_FUSE, // test_port_enable_fuse
    input wire logic LONG_TIMEOUT_FUSE, // clock-option timeout select
    output logic CORE_RESET, // holds the core in reset
    output logic [14:0] FLASH_CMD, // applied command
    output logic FLASH_CMD_STROBE, // one-cycle execute pulse
    input wire logic [14:0] CMD_RESULT, // result of last command
    input wire logic [15:0] FLASH_RD_WORD, // flash word at address
    output logic READ_ADDR_INC, // advance readout address
    output logic PAGE_WR_VALID, // page buffer write request
    input wire logic PAGE_WR_READY, // page buffer accepts
    output logic [7:0] PAGE_WR_DATA, // byte for page buffer
    output logic PAGE_WR_HIGH, // byte is high half
    output logic PAGE_WR_ADDR_INC, // pre-increment before this byte
    input wire logic HSEL, // ahb select
    input wire logic [31:0] HADDR, // ahb address
    input wire logic [1:0] HTRANS, // ahb transfer type
    input wire logic HWRITE, // ahb write
    input wire logic [2:0] HSIZE, // ahb size, words only
    input wire logic [31:0] HWDATA, // ahb write data
    input wire logic HREADY, // ahb bus ready
    output logic HREADYOUT, // never stalls
    output logic [31:0] HRDATA, // ahb read data
    output logic HRESP // always okay
);
    localparam int PAGE_WR_BOUND = `PAGE_WR_TCK * `TCK_PERIOD_NS / `CLK_PERIOD_NS;
    localparam int TW = $clog2(TOUT_LONG_CYC + 1);

    // dr shift: new bit enters at top of the selected length, lsb leaves
    function automatic logic [15:0] dr_shift(input logic [15:0] sr, input logic din,
                                             input logic [3:0] ir);
        logic [15:0] r;
        r = {1'b0, sr[15:1]};
        unique case (ir)
            `IR_UNLOCK: r[15] = din;
            `IR_COMMAND: r[14] = din;
            `IR_PAGE_IN, `IR_PAGE_OUT: begin
                r[15:7] = '0;
                r[7] = din;
            end
            default: r[0] = din;
        endcase
        return r;
    endfunction

    // input synchronisers: tck, tms, tdi, external reset
    logic [3:0] s1_q;
    logic [3:0] s2_q;
    logic tck_d_q;
    always_ff @(posedge CLK_SYS or posedge RST) begin
        if (RST) begin
            s1_q <= 4'h8;
            s2_q <= 4'h8;
            tck_d_q <= 1'b0;
        end else begin
            s1_q <= {EXT_RESET_N, TDI, TMS, TCK};
            s2_q <= s1_q;
            tck_d_q <= s2_q[0];
        end
    end
    logic tck_rise;
    logic tck_fall;
    logic tms_s;
    logic tdi_s;
    logic ext_rst_n_s;
    assign tck_rise = s2_q[0] && !tck_d_q;
    assign tck_fall = !s2_q[0] && tck_d_q;
    assign tms_s = s2_q[1];
    assign tdi_s = s2_q[2];
    assign ext_rst_n_s = s2_q[3];

    // disable bit: software sets, external reset low two clocks clears
    logic disable_q;
    logic [1:0] low_cnt_q;
    logic port_on;
    logic ahb_wr_ctrl;
    logic [31:0] ahb_wdata;
    assign ahb_wdata = HWDATA;
    assign port_on = PORT_ENABLE_FUSE && !disable_q;
    always_ff @(posedge CLK_SYS or posedge RST) begin
        if (RST) begin
            disable_q <= `DISABLE_RST;
            low_cnt_q <= '0;
        end else begin
            low_cnt_q <= ext_rst_n_s ? 2'h0 : (low_cnt_q == 2'h2 ? 2'h2 : low_cnt_q + 2'h1);
            if (!ext_rst_n_s && low_cnt_q == 2'(`DIS_CLR_CLKS - 1)) begin
                disable_q <= 1'b0;
            end else if (ahb_wr_ctrl) begin
                disable_q <= ahb_wdata[`CTRL_DISABLE_BIT];
            end
        end
    end

    // tap controller, held in test-logic-reset while port is off
    tap_state_e st_q;
    tap_state_e st_d;
    always_comb begin
        unique case (st_q)
            TLR: st_d = tms_s ? TLR : RTI;
            RTI: st_d = tms_s ? SEL_DR : RTI;
            SEL_DR: st_d = tms_s ? SEL_IR : CAP_DR;
            CAP_DR: st_d = tms_s ? EX1_DR : SH_DR;
            SH_DR: st_d = tms_s ? EX1_DR : SH_DR;
            EX1_DR: st_d = tms_s ? UPD_DR : PAU_DR;
            PAU_DR: st_d = tms_s ? EX2_DR : PAU_DR;
            EX2_DR: st_d = tms_s ? UPD_DR : SH_DR;
            UPD_DR: st_d = tms_s ? SEL_DR : RTI;
            SEL_IR: st_d = tms_s ? TLR : CAP_IR;
            CAP_IR: st_d = tms_s ? EX1_IR : SH_IR;
            SH_IR: st_d = tms_s ? EX1_IR : SH_IR;
            EX1_IR: st_d = tms_s ? UPD_IR : PAU_IR;
            PAU_IR: st_d = tms_s ? EX2_IR : PAU_IR;
            EX2_IR: st_d = tms_s ? UPD_IR : SH_IR;
            UPD_IR: st_d = tms_s ? SEL_DR : RTI;
            default: st_d = TLR;
        endcase
    end
    always_ff @(posedge CLK_SYS or posedge RST) begin
        if (RST) begin
            st_q <= TLR;
        end else if (!port_on) begin
            st_q <= TLR;
        end else if (tck_rise) begin
            st_q <= st_d;
        end
    end

    // instruction register, 4 bits, lsb first
    logic [`IR_W-1:0] ir_sr_q;
    logic [`IR_W-1:0] ir_q;
    logic instr_entered;
    assign instr_entered = tck_rise && st_q == UPD_IR;
    always_ff @(posedge CLK_SYS or posedge RST) begin
        if (RST) begin
            ir_sr_q <= '0;
            ir_q <= `IR_BYPASS;
        end else if (st_q == TLR) begin
            ir_q <= `IR_BYPASS;
        end else if (tck_rise) begin
            if (st_q == CAP_IR) ir_sr_q <= `IR_CAPTURE;
            if (st_q == SH_IR) ir_sr_q <= {tdi_s, ir_sr_q[`IR_W-1:1]};
            if (st_q == UPD_IR) ir_q <= ir_sr_q;
        end
    end

    logic dr_cap;
    logic dr_sh;
    logic dr_upd;
    assign dr_cap = tck_rise && st_q == CAP_DR;
    assign dr_sh = tck_rise && st_q == SH_DR;
    assign dr_upd = tck_rise && st_q == UPD_DR;

    // reset bit lives in the chain itself, so it acts unlatched
    logic rst_bit_q;
    logic [TW-1:0] tout_q;
    always_ff @(posedge CLK_SYS or posedge RST) begin
        if (RST) begin
            rst_bit_q <= 1'b0;
            tout_q <= '0;
        end else begin
            if (dr_sh && ir_q == `IR_RESET) rst_bit_q <= tdi_s;
            if (rst_bit_q) begin
                tout_q <= LONG_TIMEOUT_FUSE ? TW'(TOUT_LONG_CYC) :
                          TW'(TOUT_SHORT_CYC);
            end else if (tout_q != '0) begin
                tout_q <= tout_q - 1'b1;
            end
        end
    end
    assign CORE_RESET = rst_bit_q || (tout_q != '0);

    // shared data shift register; page byte is its low eight bits
    logic [15:0] dr_sr_q;
    logic byte_hi_q;
    logic first_q;
    logic [7:0] rd_byte;
    assign rd_byte = byte_hi_q ? FLASH_RD_WORD[15:8] : FLASH_RD_WORD[7:0];
    always_ff @(posedge CLK_SYS or posedge RST) begin
        if (RST) begin
            dr_sr_q <= '0;
        end else if (dr_cap) begin
            unique case (ir_q)
                `IR_COMMAND: dr_sr_q <= {1'b0, CMD_RESULT};
                `IR_PAGE_OUT: dr_sr_q <= {8'h00, rd_byte};
                default: dr_sr_q <= '0;
            endcase
        end else if (dr_sh) begin
            dr_sr_q <= dr_shift(dr_sr_q, tdi_s, ir_q);
        end
    end

    // unlock: cleared by power-on reset or by an update with a wrong key, compared on update
    logic prog_q;
    always_ff @(posedge CLK_SYS or posedge RST) begin
        if (RST) begin
            prog_q <= 1'b0;
        end else if (dr_upd && ir_q == `IR_UNLOCK) begin
            prog_q <= (dr_sr_q == `UNLOCK_KEY);
        end
    end

    // command apply on update, execute pulse per tck edge in idle
    always_ff @(posedge CLK_SYS or posedge RST) begin
        if (RST) begin
            FLASH_CMD <= '0;
            FLASH_CMD_STROBE <= 1'b0;
        end else begin
            if (dr_upd && ir_q == `IR_COMMAND && prog_q) FLASH_CMD <= dr_sr_q[14:0];
            FLASH_CMD_STROBE <= tck_rise && st_q == RTI &&
                                ir_q == `IR_COMMAND && prog_q;
        end
    end

    // byte phase for page streams, restarted when an instruction is loaded
    logic ld_pend_q;
    logic [9:0] ld_word_q;
    logic fifo_in_ready;
    always_ff @(posedge CLK_SYS or posedge RST) begin
        if (RST) begin
            byte_hi_q <= 1'b0;
            first_q <= 1'b1;
            READ_ADDR_INC <= 1'b0;
        end else begin
            READ_ADDR_INC <= 1'b0;
            if (instr_entered) begin
                byte_hi_q <= 1'b0;
                first_q <= 1'b1;
            end else if (dr_upd && ir_q == `IR_PAGE_IN && prog_q) begin
                byte_hi_q <= !byte_hi_q;
                first_q <= 1'b0;
            end else if (dr_cap && ir_q == `IR_PAGE_OUT && prog_q) begin
                byte_hi_q <= !byte_hi_q;
                READ_ADDR_INC <= byte_hi_q;
            end
        end
    end

    // temporary byte waits here while the fifo is full
    always_ff @(posedge CLK_SYS or posedge RST) begin
        if (RST) begin
            ld_pend_q <= 1'b0;
            ld_word_q <= '0;
        end else if (dr_upd && ir_q == `IR_PAGE_IN && prog_q) begin
            ld_pend_q <= 1'b1;
            ld_word_q <= {!byte_hi_q && !first_q, byte_hi_q, dr_sr_q[7:0]};
        end else if (fifo_in_ready) begin
            ld_pend_q <= 1'b0;
        end
    end

    // drain side stalls on page buffer, pending byte holds behind it
    logic [9:0] fifo_out;
    page_fifo #(.WIDTH(10), .DEPTH(FIFO_DEPTH)) u_fifo (
        .clk(CLK_SYS),
        .rst(RST),
        .in_valid(ld_pend_q),
        .in_ready(fifo_in_ready),
        .in_data(ld_word_q),
        .out_valid(PAGE_WR_VALID),
        .out_ready(PAGE_WR_READY),
        .out_data(fifo_out)
    );
    assign PAGE_WR_ADDR_INC = fifo_out[9];
    assign PAGE_WR_HIGH = fifo_out[8];
    assign PAGE_WR_DATA = fifo_out[7:0];

    // tdo changes on falling tck, driven only while shifting
    always_ff @(posedge CLK_SYS or posedge RST) begin
        if (RST) begin
            TDO <= 1'b0;
            TDO_OE_N <= 1'b1;
        end else if (tck_fall) begin
            TDO <= (st_q == SH_IR) ? ir_sr_q[0] :
                   (ir_q == `IR_RESET) ? rst_bit_q : dr_sr_q[0];
            TDO_OE_N <= !(st_q == SH_IR || st_q == SH_DR);
        end
    end

    // ahb-lite slave, zero wait, read data set up in address phase
    logic dph_wr_q;
    logic [31:0] dph_addr_q;
    logic ahb_go;
    assign ahb_go = HSEL && HTRANS[1] && HREADY;
    assign ahb_wr_ctrl = dph_wr_q && dph_addr_q == `OFS_CTRL;
    assign HREADYOUT = 1'b1;
    assign HRESP = 1'b0;
    always_ff @(posedge CLK_SYS or posedge RST) begin
        if (RST) begin
            dph_wr_q <= 1'b0;
            dph_addr_q <= '0;
            HRDATA <= '0;
        end else begin
            dph_wr_q <= ahb_go && HWRITE;
            if (ahb_go) dph_addr_q <= HADDR;
            if (ahb_go && !HWRITE) begin
                HRDATA <= '0; // unmapped reads as zero
                if (HADDR == `OFS_CTRL) HRDATA[`CTRL_DISABLE_BIT] <= disable_q;
                if (HADDR == `OFS_STATUS) begin
                    HRDATA[`ST_PROG_BIT] <= prog_q;
                    HRDATA[`ST_RESET_BIT] <= CORE_RESET;
                    HRDATA[`ST_PORT_BIT] <= port_on;
                    HRDATA[`ST_IR_LSB +: 4] <= ir_q;
                end
            end
        end
    end

    // checks
    a_unlock_compare: assert property (@(posedge CLK_SYS) disable iff (RST)
        dr_upd && ir_q == `IR_UNLOCK |=> prog_q == ($past(dr_sr_q) == `UNLOCK_KEY))
        else $error("unlock result does not match key compare");
    a_reset_immediate: assert property (@(posedge CLK_SYS) disable iff (RST)
        dr_sh && ir_q == `IR_RESET && tdi_s |=> rst_bit_q && CORE_RESET)
        else $error("reset bit set but core not in reset");
    a_reset_timeout: assert property (@(posedge CLK_SYS) disable iff (RST)
        $fell(rst_bit_q) |-> CORE_RESET [*8])
        else $error("core left reset before timeout");
    a_cmd_locked: assert property (@(posedge CLK_SYS) disable iff (RST)
        !prog_q |=> !FLASH_CMD_STROBE && $stable(FLASH_CMD))
        else $error("command acted without unlock");
    a_cmd_apply: assert property (@(posedge CLK_SYS) disable iff (RST)
        dr_upd && ir_q == `IR_COMMAND && prog_q |=> FLASH_CMD == $past(dr_sr_q[14:0]))
        else $error("command not applied on update");
    a_lsb_first: assert property (@(posedge CLK_SYS) disable iff (RST)
        dr_sh && ir_q == `IR_COMMAND |=> dr_sr_q[13:0] == $past(dr_sr_q[14:1])
        && dr_sr_q[14] == $past(tdi_s))
        else $error("command register not shifted lsb first");
    a_page_write_bound: assert property (@(posedge CLK_SYS) disable iff (RST)
        dr_upd && ir_q == `IR_PAGE_IN && prog_q && !PAGE_WR_VALID && PAGE_WR_READY
        |-> ##[1:PAGE_WR_BOUND] PAGE_WR_VALID)
        else $error("page byte not offered to buffer in time");
    a_first_no_inc: assert property (@(posedge CLK_SYS) disable iff (RST)
        dr_upd && ir_q == `IR_PAGE_IN && prog_q && first_q |=> !ld_word_q[9] && !ld_word_q[8])
        else $error("first page byte must be low without increment");
    a_read_inc_high: assert property (@(posedge CLK_SYS) disable iff (RST)
        READ_ADDR_INC |-> !byte_hi_q && $past(byte_hi_q))
        else $error("readout increment not after high byte");
    a_port_off_tlr: assert property (@(posedge CLK_SYS) disable iff (RST)
        !port_on |=> st_q == TLR)
        else $error("tap active while port disabled");
    c_unlocked: cover property (@(posedge CLK_SYS) disable iff (RST) $rose(prog_q));
    c_page_write: cover property (@(posedge CLK_SYS) disable iff (RST)
        PAGE_WR_VALID && PAGE_WR_READY && PAGE_WR_HIGH);
    c_read_inc: cover property (@(posedge CLK_SYS) disable iff (RST) READ_ADDR_INC);
endmodule

`default_nettype wire

// ### src/jtag_prog_consts.svh
// constants for the test-port flash programming block
// How it works
// - instruction register is four bits wide
// - all shift registers move least bit first
// - code 0xC selects reset bit, tap untouched
// - reset bit one holds core reset immediately
// - reset persists for fuse-selected timeout after clearing
// - code 0x4 shifts key, update compares
// - programming enabled only on exact fixed key
// - unlock register cleared on power-on reset
// - code 0x5 command register captures previous result
// - update applies command, idle pass strobes it
// - code 0x6 page byte is command low byte
// - page byte reaches page buffer within 11 tck
// - page load alternates low/high, pre-increment address
// - code 0x7 captures flash byte, low first
// - readout increments address after every high byte
// - port needs fuse and clear disable bit
`ifndef JTAG_PROG_CONSTS_SVH
`define JTAG_PROG_CONSTS_SVH
`define IR_W 4
`define IR_RESET 4'hc
`define IR_UNLOCK 4'h4
`define IR_COMMAND 4'h5
`define IR_PAGE_IN 4'h6
`define IR_PAGE_OUT 4'h7
`define IR_BYPASS 4'hf
`define IR_CAPTURE 4'h1
`define UNLOCK_W 16
`define CMD_W 15
`define BYTE_W 8
`define UNLOCK_KEY 16'ha370
`define UNLOCK_RST 16'h0000
`define OFS_CTRL 32'h0000_0000
`define OFS_STATUS 32'h0000_0004
`define CTRL_DISABLE_BIT 0
`define ST_PROG_BIT 0
`define ST_RESET_BIT 1
`define ST_PORT_BIT 2
`define ST_IR_LSB 4
`define DISABLE_RST 1'b0
`define DIS_CLR_CLKS 2
`define PAGE_WR_TCK 11
`define TCK_PERIOD_NS 160
`define CLK_PERIOD_NS 10
`endif

// ### src/jtag_prog_pkg.sv
// types shared by the test-port flash programming block
package jtag_prog_pkg;
    typedef enum logic [15:0] {
        TLR = 16'h0001, RTI = 16'h0002, SEL_DR = 16'h0004, CAP_DR = 16'h0008,
        SH_DR = 16'h0010, EX1_DR = 16'h0020, PAU_DR = 16'h0040, EX2_DR = 16'h0080,
        UPD_DR = 16'h0100, SEL_IR = 16'h0200, CAP_IR = 16'h0400, SH_IR = 16'h0800,
        EX1_IR = 16'h1000, PAU_IR = 16'h2000, EX2_IR = 16'h4000, UPD_IR = 16'h8000
    } tap_state_e;
endpackage

// ### tb/jtag_programmer.sv
// programmer model driving the four test access port pins
`timescale 1ns/100ps
`default_nettype none

module jtag_programmer #(
    parameter int HALF_NS = 80 // slow tck, far below the chip limit
) (
    output logic tck, // test clock, still between frames
    output logic tms, // mode select
    output logic tdi, // data into the device
    input wire logic tdo // data from the device
);
    initial begin
        tck = 1'b0;
        tms = 1'b1;
        tdi = 1'b0;
    end

    // one tck period; tdo sampled just before the rise, a half period after it moved
    task automatic step(input logic ms, input logic di, output logic so);
        tms = ms;
        tdi = di;
        #(HALF_NS);
        so = tdo;
        tck = 1'b1;
        #(HALF_NS);
        tck = 1'b0;
    endtask

    // five ones reach test-logic-reset from any state, then park in idle
    task automatic park();
        logic so;
        repeat (5) step(1'b1, 1'b0, so);
        step(1'b0, 1'b0, so);
    endtask

    task automatic idle(input int n);
        logic so;
        repeat (n) step(1'b0, 1'b0, so);
    endtask

    // idle to idle scan of ir or dr, lsb first in both directions
    task automatic shift(input bit ir, input int n, input logic [15:0] din,
            output logic [15:0] dout);
        logic so;
        dout = 16'h0000;
        #3;
        step(1'b1, 1'b0, so);
        if (ir) step(1'b1, 1'b0, so);
        step(1'b0, 1'b0, so);
        step(1'b0, 1'b0, so);
        for (int i = 0; i < n; i++) begin
            step(i == n - 1, din[i], so);
            dout[i] = so;
        end
        step(1'b1, 1'b0, so);
        step(1'b0, 1'b0, so);
        // a released line shows the inverse, never a stale bit
        tdi = ~tdi;
    endtask
endmodule

`default_nettype wire

// ### tb/jtag_prog_port_tb_top.sv
// self-checking bench for the test-port programming block
`timescale 1ns/100ps
`default_nettype none
`include "jtag_prog_consts.svh"
`define CHK(g, e) check(32'(g), 32'(e))

module jtag_prog_port_tb_top
    import jtag_prog_pkg::*;
;
    localparam int T_SHORT = 60;
    localparam int T_LONG = 240;
    int seed = 32'h976efe09;
    int n_mismatch = 0;
    int n_checks = 0;
    int cyc = 0;
    int n_strobe = 0;
    int n_inc = 0;
    logic clk, rst, tck, tms, tdi, tdo, tdo_oe_n, ext_rst_n, port_fuse, long_fuse;
    logic core_reset, cmd_strobe, addr_inc, pg_valid, pg_ready, pg_high, pg_inc, stall;
    logic [14:0] flash_cmd, cmd_result;
    logic [15:0] flash_word;
    logic [7:0] pg_data;
    logic hsel, hwrite, hreadyout, hresp;
    logic [1:0] htrans;
    logic [2:0] hsize;
    logic [31:0] haddr, hwdata, hrdata;
    logic [9:0] got_q[$];
    logic [9:0] exp_q[$];

    jtag_prog_port #(.TOUT_SHORT_CYC(T_SHORT), .TOUT_LONG_CYC(T_LONG), .FIFO_DEPTH(4)) uut (
        .CLK_SYS(clk), .RST(rst), .TCK(tck), .TMS(tms), .TDI(tdi), .TDO(tdo),
        .TDO_OE_N(tdo_oe_n), .EXT_RESET_N(ext_rst_n), .PORT_ENABLE_FUSE(port_fuse),
        .LONG_TIMEOUT_FUSE(long_fuse), .CORE_RESET(core_reset), .FLASH_CMD(flash_cmd),
        .FLASH_CMD_STROBE(cmd_strobe), .CMD_RESULT(cmd_result),
        .FLASH_RD_WORD(flash_word), .READ_ADDR_INC(addr_inc), .PAGE_WR_VALID(pg_valid),
        .PAGE_WR_READY(pg_ready), .PAGE_WR_DATA(pg_data), .PAGE_WR_HIGH(pg_high),
        .PAGE_WR_ADDR_INC(pg_inc), .HSEL(hsel), .HADDR(haddr), .HTRANS(htrans),
        .HWRITE(hwrite), .HSIZE(hsize), .HWDATA(hwdata), .HREADY(hreadyout),
        .HREADYOUT(hreadyout), .HRDATA(hrdata), .HRESP(hresp));

    jtag_programmer prog (.tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo));

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    task automatic check(input logic [31:0] g, input logic [31:0] e);
        n_checks++;
        if (g !== e) begin
            n_mismatch++;
            $display("FAIL t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask

    task automatic results();
        $display("checks=%0d mismatches=%0d", n_checks, n_mismatch);
        if (n_mismatch == 0 && n_checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    // single whole-word transfer; waits on hready, never on a fixed count
    task automatic ahb(input logic wr, input logic [31:0] a, input logic [31:0] wd,
            output logic [31:0] rd);
        @(posedge clk);
        hsel <= 1'b1;
        haddr <= a;
        htrans <= 2'b10;
        hwrite <= wr;
        do @(posedge clk); while (hreadyout !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'b00;
        hwdata <= wd;
        do @(posedge clk); while (hreadyout !== 1'b1);
        rd = hrdata;
    endtask

    task automatic wait_q(input int n, input int lim);
        int c;
        c = 0;
        while (got_q.size() < n && c < lim) begin
            @(posedge clk);
            c++;
        end
    endtask

    // page words alternate low/high; address steps before every low but the first
    function automatic logic [9:0] page_exp(input int j, input logic [7:0] b);
        return {1'(j % 2 == 0 && j > 0), 1'(j % 2), b};
    endfunction

    // page buffer sink, flash array and pulse counters; stalls at random
    always @(posedge clk) begin
        cyc <= cyc + 1;
        pg_ready <= !stall && (($random(seed) & 3) != 0);
        if (pg_valid === 1'b1 && pg_ready === 1'b1) got_q.push_back({pg_inc, pg_high, pg_data});
        if (cmd_strobe === 1'b1) n_strobe++;
        if (addr_inc === 1'b1) begin
            n_inc++;
            flash_word <= 16'($random(seed));
        end
        if (cyc == 40000) begin
            n_mismatch++;
            results();
        end
    end

    initial begin
        logic [15:0] o;
        logic [15:0] k;
        logic [15:0] w;
        logic [31:0] d;
        logic [14:0] cmd;
        logic [7:0] b;
        int n;
        int t;
        rst = 1'b1;
        ext_rst_n = 1'b1;
        port_fuse = 1'b1;
        long_fuse = 1'b0;
        cmd_result = 15'h0000;
        flash_word = 16'h1234;
        pg_ready = 1'b0;
        stall = 1'b1;
        hsel = 1'b0;
        haddr = 32'h0;
        htrans = 2'b00;
        hwrite = 1'b0;
        hsize = 3'b010;
        hwdata = 32'h0;
        repeat (5) @(posedge clk);
        rst <= 1'b0;
        ahb(1'b0, `OFS_STATUS, 32'h0, d);
        `CHK(d, 32'h0000_00f4);
        ahb(1'b0, 32'h0000_0008, 32'h0, d);
        `CHK(d, 32'h0);
        `CHK(tdo_oe_n, 1'b1);
        `CHK(hresp, 1'b0);
        prog.park();
        // core reset bit, then the timeout for both clock-option settings
        for (int f = 0; f < 2; f++) begin
            @(posedge clk);
            long_fuse <= f[0];
            t = f ? T_LONG : T_SHORT;
            prog.shift(1'b1, 4, `IR_RESET, o);
            `CHK(o[3:0], 4'b0001);
            prog.shift(1'b0, 1, 16'h0001, o);
            `CHK(core_reset, 1'b1);
            ahb(1'b0, `OFS_STATUS, 32'h0, d);
            `CHK(d[7:4], `IR_RESET);
            `CHK(d[1], 1'b1);
            prog.shift(1'b0, 1, 16'h0000, o);
            `CHK(core_reset, 1'b1);
            n = 0;
            while (core_reset === 1'b1 && n < 400) begin
                @(posedge clk);
                n++;
            end
            `CHK(n > t - 50 && n < t - 20, 1'b1);
        end
        // part was reset above; wrong keys first, bit-reversed one among them
        for (int i = 0; i < 6; i++) begin
            k = i > 2 ? `UNLOCK_KEY : i == 1 ? 16'h0ec5 : `UNLOCK_KEY ^ 16'h0001;
            if (i == 2) k = 16'($random(seed)) | 16'h0001;
            prog.shift(1'b1, 4, `IR_UNLOCK, o);
            prog.shift(1'b0, 16, k, o);
            ahb(1'b0, `OFS_STATUS, 32'h0, d);
            `CHK(d[0], k == `UNLOCK_KEY);
            @(posedge clk);
            cmd_result <= 15'($random(seed));
            cmd = 15'($random(seed));
            prog.shift(1'b1, 4, `IR_COMMAND, o);
            prog.shift(1'b0, 15, {1'b0, cmd}, o);
            if (i > 2) `CHK(o[14:0], cmd_result);
            `CHK(flash_cmd, i > 2 ? cmd : 15'h0);
            n_strobe = 0;
            prog.idle(3);
            `CHK(n_strobe, i > 2 ? 3 : 0);
        end
        // page stream: five bytes held by a stalled sink, then flowing
        prog.shift(1'b1, 4, `IR_PAGE_IN, o);
        got_q.delete();
        for (int j = 0; j < 10; j++) begin
            b = 8'($random(seed));
            exp_q.push_back(page_exp(j, b));
            if (j == 5) begin
                `CHK(pg_valid, 1'b1);
                `CHK(got_q.size(), 0);
                stall = 1'b0;
                wait_q(5, 200);
            end
            prog.shift(1'b0, 8, {8'h00, b}, o);
            if (j >= 5) begin
                wait_q(j + 1, 11 * 16);
                `CHK(got_q.size(), j + 1);
            end
        end
        foreach (exp_q[j]) `CHK(got_q[j], exp_q[j]);
        // readout alternates low/high, address steps after each high byte
        prog.shift(1'b1, 4, `IR_PAGE_OUT, o);
        n_inc = 0;
        for (int j = 0; j < 6; j++) begin
            w = flash_word;
            prog.shift(1'b0, 8, 16'h00ff, o);
            `CHK(o[7:0], j % 2 ? w[15:8] : w[7:0]);
            `CHK(n_inc, (j + 1) / 2);
        end
        // leaving programming clears the unlock register
        prog.shift(1'b1, 4, `IR_UNLOCK, o);
        prog.shift(1'b0, 16, 16'h0000, o);
        ahb(1'b0, `OFS_STATUS, 32'h0, d);
        `CHK(d[0], 1'b0);
        // disable bit from software, cleared by the external reset pin
        ahb(1'b1, `OFS_CTRL, 32'h1, d);
        ahb(1'b0, `OFS_STATUS, 32'h0, d);
        `CHK(d[2], 1'b0);
        ext_rst_n <= 1'b0;
        repeat (6) @(posedge clk);
        ext_rst_n <= 1'b1;
        ahb(1'b0, `OFS_CTRL, 32'h0, d);
        `CHK(d, 32'h0);
        port_fuse <= 1'b0;
        repeat (3) @(posedge clk);
        ahb(1'b0, `OFS_STATUS, 32'h0, d);
        `CHK(d[2], 1'b0);
        port_fuse <= 1'b1;
        repeat (3) @(posedge clk);
        // power-on reset in mid-run drops a valid unlock
        prog.park();
        prog.shift(1'b1, 4, `IR_UNLOCK, o);
        prog.shift(1'b0, 16, `UNLOCK_KEY, o);
        @(posedge clk);
        rst <= 1'b1;
        @(posedge clk);
        rst <= 1'b0;
        ahb(1'b0, `OFS_STATUS, 32'h0, d);
        `CHK(d[0], 1'b0);
        results();
    end
endmodule

`default_nettype wire
